// ### common/pmid_params.svh
// Constants for the checksum, fault-injection and identification register group.
// Assumes inclusion by the package and the design modules; definitions only.
`ifndef PMID_PARAMS_SVH
`define PMID_PARAMS_SVH
// =====================================================================
// Command codes
`define PMID_CMD_CRC        8'hf0
`define PMID_CMD_INJECT     8'hf1
`define PMID_CMD_IDENT      8'hfc
// =====================================================================
// Injection word fields
`define PMID_BIT_FAULT_HOLD 4'd15
`define PMID_BIT_OVERTEMP   4'd14
`define PMID_BIT_OC_FAULT   4'd12
`define PMID_BIT_IN_LOCKOUT 4'd11
`define PMID_BIT_IN_OV      4'd10
`define PMID_BIT_OUT_UV     4'd9
`define PMID_BIT_OUT_OV     4'd8
`define PMID_BIT_WARN_HOLD  4'd7
`define PMID_BIT_OC_WARN    4'd4
`define PMID_BIT_IN_UVW     4'd3
`define PMID_BIT_OUT_UVW    4'd1
`define PMID_BIT_OUT_OVW    4'd0
`define PMID_FAULT_MASK     16'h5f00
`define PMID_WARN_MASK      16'h001b
`define PMID_INJECT_RESET   16'h0000
// =====================================================================
// CRC and identity
`define PMID_CRC_POLY       16'h8005
`define PMID_CRC_INIT       16'h0000
// Arbitrary identity value, not any real part's code
`define PMID_IDENT_DEFAULT  16'h5a3c
`endif

// ### common/pmid_pkg.sv
// Types shared by the register group modules.
// Assumes the params header sits beside it on the include path.
`include "pmid_params.svh"
package pmid_pkg;
  // =====================================================================
  // Register command from the PMBus target logic
  typedef struct packed {
    logic       rd;      // Read-word strobe
    logic       wr;      // Write-word strobe
    logic [7:0] code;    // Command code
    logic [15:0] wdata;  // Write word
  } pmid_cmd_t;
  // Register answer to the PMBus target logic
  typedef struct packed {
    logic        ack;    // Answer valid pulse
    logic        nak;    // Command not defined here
    logic [15:0] rdata;  // Read word
  } pmid_rsp_t;
  // Checksum walker states
  typedef enum logic [1:0] {
    PMID_CRC_IDLE = 2'b00,
    PMID_CRC_RUN  = 2'b01,
    PMID_CRC_DONE = 2'b10
  } pmid_crc_state_t;
endpackage

// ### hdl/pmid_crc16.sv
// Serial CRC-16 over a settings image supplied one word per cycle.
// Assumes the word source answers the index combinationally.
`timescale 1ns/1ps
`include "pmid_params.svh"
module pmid_crc16 import pmid_pkg::*; #(
  parameter int WORDS = 16
) (
  input  wire logic                     clock,
  input  wire logic                     rstn,
  input  wire logic                     start,
  input  wire logic [15:0]              word_in,
  output logic [$clog2(WORDS)-1:0]      word_idx,
  output logic                          busy,
  output logic                          done,
  output logic [15:0]                   crc
);
  // Elaboration check: the walker needs at least two words
  if (WORDS < 2) begin : g_words_chk
    $error("WORDS must be at least 2");
  end
  pmid_crc_state_t            state_q;  // Walker state
  logic [$clog2(WORDS)-1:0]   idx_q;    // Word index
  logic [15:0]                acc_q;    // Running remainder
  logic [15:0]                acc_d;    // Remainder after this word
  // Sixteen shift steps of the 0x8005 polynomial
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ `PMID_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
  assign acc_d    = crc_word(acc_q, word_in);
  assign word_idx = idx_q;
  assign busy     = (state_q == PMID_CRC_RUN);
  assign done     = (state_q == PMID_CRC_DONE);
  assign crc      = acc_q;
  // =====================================================================
  // Walker
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= PMID_CRC_IDLE;
      idx_q   <= '0;
      acc_q   <= `PMID_CRC_INIT;
    end else begin
      case (state_q)
        PMID_CRC_IDLE: begin
          if (start) begin
            state_q <= PMID_CRC_RUN;
            idx_q   <= '0;
            acc_q   <= `PMID_CRC_INIT;
          end
        end
        PMID_CRC_RUN: begin
          acc_q <= acc_d;
          if (idx_q == ($clog2(WORDS))'(WORDS - 1)) begin
            state_q <= PMID_CRC_DONE;
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        default: begin
          state_q <= PMID_CRC_IDLE;
        end
      endcase
    end
  end
endmodule

// ### hdl/pmid_inject.sv
// Injection word storage and the gating of injected detector trips.
// Assumes a one-cycle fault-response pulse from the protection logic.
`timescale 1ns/1ps
`include "pmid_params.svh"
module pmid_inject import pmid_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  input  wire logic        fault_response,
  input  wire logic        conv_enabled,
  output logic [15:0]      word,
  output logic [15:0]      trips
);
  logic [15:0] word_q;   // Stored injection word
  logic        fault_live_q; // Fault injections still armed
  logic        warn_live_q;  // Warning injections still armed
  logic [15:0] armed;    // Armed and mapped bits
  logic [15:0] allowed;  // Bits allowed in present conversion state
  assign word  = word_q;
  // Only mapped bits drive trips; reserved bits stay inert
  assign armed = (word_q & `PMID_FAULT_MASK & {16{fault_live_q}}) |
                 (word_q & `PMID_WARN_MASK & {16{warn_live_q}});
  // Lockout and output overvoltage act even when stopped
  assign allowed = conv_enabled ? 16'hffff :
                   ((16'h0001 << `PMID_BIT_IN_LOCKOUT) | (16'h0001 << `PMID_BIT_OUT_OV));
  assign trips = armed & allowed;
  // =====================================================================
  // Storage and one-shot clearing; a new write wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word_q       <= `PMID_INJECT_RESET;
      fault_live_q <= 1'b0;
      warn_live_q  <= 1'b0;
    end else if (wr) begin
      word_q       <= wdata;
      fault_live_q <= 1'b1;
      warn_live_q  <= 1'b1;
    end else if (fault_response) begin
      if (!word_q[`PMID_BIT_FAULT_HOLD]) fault_live_q <= 1'b0;
      if (!word_q[`PMID_BIT_WARN_HOLD])  warn_live_q  <= 1'b0;
    end
  end
  ovr_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    (fault_response && !wr && !word_q[15]) |=> ((trips & `PMID_FAULT_MASK) == 16'h0000))
    else $error("fault injection survived a response");
  warn_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (fault_response && !wr && word_q[7] && warn_live_q) |=> warn_live_q)
    else $error("held warning injection dropped");
  stop_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    !conv_enabled |-> ((trips & 16'h561b) == 16'h0000))
    else $error("gated injection acted while stopped");
endmodule

// ### hdl/pmid_regs.sv
// Checksum, fault-injection and identification registers of the PMBus target.
// Assumes the PMBus target logic decodes read-word/write-word into one-cycle
// strobes on this clock, and the settings store answers an index combinationally.
`timescale 1ns/1ps
`include "pmid_params.svh"
// Summary of operation
// - CRC-16 poly 0x8005 over stored settings
// - Recompute checksum at boot, store, restore
// - Checksum read-only word at F0h
// - Injection bits force matching detector trips
// - Fault hold clear means one-shot faults
// - Warning hold clear means one-shot warnings
// - Fault bits map to their detectors
// - Warning bits map to their detectors
// - Only lockout, output overvolt act stopped
// - Identity word fixed; writes acknowledged, ignored
// - Identity writes raise no comm error
module pmid_regs import pmid_pkg::*; #(
  parameter int          SETTINGS_WORDS = 16,
  parameter logic [15:0] IDENT_VALUE    = `PMID_IDENT_DEFAULT  // Arbitrary value
) (
  input  wire logic                              clock,
  input  wire logic                              rstn,
  input  wire pmid_cmd_t                         cmd,
  output pmid_rsp_t                              rsp,
  output logic                                   comm_error_status,
  input  wire logic                              store_done,
  input  wire logic                              restore_done,
  input  wire logic [15:0]                       settings_word,
  output logic [$clog2(SETTINGS_WORDS)-1:0]      settings_idx,
  output logic                                   crc_busy,
  input  wire logic                              fault_response,
  input  wire logic                              conv_enabled,
  output logic                                   inject_overtemp_fault,
  output logic                                   inject_overcurrent_fault,
  output logic                                   inject_input_lockout,
  output logic                                   inject_input_overvolt_fault,
  output logic                                   inject_output_undervolt_fault,
  output logic                                   inject_output_overvolt_fault,
  output logic                                   inject_overcurrent_warn,
  output logic                                   inject_input_undervolt_warn,
  output logic                                   inject_output_undervolt_warn,
  output logic                                   inject_output_overvolt_warn
);
  // Elaboration check: the walker needs at least two words
  if (SETTINGS_WORDS < 2) begin : g_words_chk
    $error("SETTINGS_WORDS must be at least 2");
  end
  // =====================================================================
  // Declarations
  logic        redo_q;         // Walk request pending (boot, store, restore)
  logic        crc_take;       // Walker accepts a start this cycle
  logic        crc_start;      // Start pulse to walker
  logic        crc_done;       // Walker finished
  logic [15:0] crc_acc;        // Walker remainder
  logic        crc_walk;       // Walker running
  logic [15:0] crc_q;          // Published checksum
  logic [15:0] inj_word;       // Stored injection word
  logic [15:0] trips;          // Gated injected trips
  logic [15:0] trips_q;        // Registered trips
  logic [$clog2(SETTINGS_WORDS)-1:0] idx_w; // Walker index
  logic        hit_crc;        // Command addresses checksum
  logic        hit_inj;        // Command addresses injection word
  logic        hit_id;         // Command addresses identity word
  logic        bad_cmd;        // Undefined access for this group
  logic [15:0] rdata_d;        // Read word selected
  pmid_rsp_t   rsp_q;          // Registered answer
  logic        comm_err_q;     // Communication error pulse
  logic        crc_busy_q;     // Registered walker activity
  // =====================================================================
  // Command decode
  assign hit_crc = (cmd.code == `PMID_CMD_CRC);
  assign hit_inj = (cmd.code == `PMID_CMD_INJECT);
  assign hit_id  = (cmd.code == `PMID_CMD_IDENT);
  // A write to the checksum is not defined, so it is an error
  // Identity writes are accepted silently
  assign bad_cmd = (cmd.wr && hit_crc) || ((cmd.rd || cmd.wr) && !(hit_crc || hit_inj || hit_id));
  // Read word selection
  assign rdata_d = hit_crc ? crc_q :
                   hit_inj ? inj_word :
                   hit_id  ? IDENT_VALUE :
                   16'h0000;
  // Start the walker at boot or after a store or restore
  assign crc_start = redo_q || store_done || restore_done;
  // The walker only takes a start while idle
  assign crc_take  = crc_start && !crc_walk && !crc_done;
  // =====================================================================
  // Submodules
  pmid_crc16 #(
    .WORDS   (SETTINGS_WORDS)
  ) u_crc (
    .clock   (clock),
    .rstn    (rstn),
    .start   (crc_start),
    .word_in (settings_word),
    .word_idx(idx_w),
    .busy    (crc_walk),
    .done    (crc_done),
    .crc     (crc_acc)
  );
  pmid_inject u_inj (
    .clock         (clock),
    .rstn          (rstn),
    .wr            (cmd.wr && hit_inj),
    .wdata         (cmd.wdata),
    .fault_response(fault_response),
    .conv_enabled  (conv_enabled),
    .word          (inj_word),
    .trips         (trips)
  );
  // =====================================================================
  // Pending walk: set at reset for boot, kept while a walk runs so a store
  // or restore that lands mid-walk is not lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      redo_q <= 1'b1;
    end else if (crc_take) begin
      redo_q <= 1'b0;
    end else if (store_done || restore_done) begin
      redo_q <= 1'b1;
    end
  end
  // Published checksum, taken when a walk ends
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crc_q <= `PMID_CRC_INIT;
    end else if (crc_done) begin
      crc_q <= crc_acc;
    end
  end
  // =====================================================================
  // Answer register: ack for every command, nak for undefined ones
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_q      <= '0;
      comm_err_q <= 1'b0;
    end else begin
      rsp_q.ack   <= cmd.rd || cmd.wr;
      rsp_q.nak   <= bad_cmd;
      rsp_q.rdata <= cmd.rd ? rdata_d : 16'h0000;
      comm_err_q  <= bad_cmd;
    end
  end
  // Registered trips and walker status
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trips_q    <= '0;
      crc_busy_q <= 1'b0;
    end else begin
      trips_q    <= trips;
      crc_busy_q <= crc_walk;
    end
  end
  // =====================================================================
  // Outputs
  assign rsp               = rsp_q;
  assign comm_error_status = comm_err_q;
  assign crc_busy          = crc_busy_q;
  assign settings_idx      = idx_w;
  assign inject_overtemp_fault         = trips_q[`PMID_BIT_OVERTEMP];
  assign inject_overcurrent_fault      = trips_q[`PMID_BIT_OC_FAULT];
  assign inject_input_lockout          = trips_q[`PMID_BIT_IN_LOCKOUT];
  assign inject_input_overvolt_fault   = trips_q[`PMID_BIT_IN_OV];
  assign inject_output_undervolt_fault = trips_q[`PMID_BIT_OUT_UV];
  assign inject_output_overvolt_fault  = trips_q[`PMID_BIT_OUT_OV];
  assign inject_overcurrent_warn       = trips_q[`PMID_BIT_OC_WARN];
  assign inject_input_undervolt_warn   = trips_q[`PMID_BIT_IN_UVW];
  assign inject_output_undervolt_warn  = trips_q[`PMID_BIT_OUT_UVW];
  assign inject_output_overvolt_warn   = trips_q[`PMID_BIT_OUT_OVW];
  // =====================================================================
  // Checks
  sequence write_ident_s;
    cmd.wr && hit_id;
  endsequence
  ident_fixed_a: assert property (@(posedge clock) disable iff (!rstn)
    (cmd.rd && hit_id) |=> (rsp.ack && rsp.rdata == IDENT_VALUE))
    else $error("identity word read back wrong");
  ident_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    write_ident_s |=> (rsp.ack && !rsp.nak && !comm_error_status))
    else $error("identity write flagged an error");
  crc_rdonly_a: assert property (@(posedge clock) disable iff (!rstn)
    (cmd.wr && hit_crc) |=> (comm_error_status && $stable(crc_q)))
    else $error("checksum write not refused");
  crc_redo_a: assert property (@(posedge clock) disable iff (!rstn)
    (store_done && !crc_walk && !crc_done) |=> crc_walk)
    else $error("store did not restart checksum");
  crc_pend_a: assert property (@(posedge clock) disable iff (!rstn)
    ((store_done || restore_done) && (crc_walk || crc_done)) |=> redo_q)
    else $error("mid-walk store request lost");
  crc_publish_a: assert property (@(posedge clock) disable iff (!rstn)
    crc_done |=> (crc_q == $past(crc_acc)))
    else $error("checksum not published");
  inj_map_a: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> (inject_overtemp_fault == $past(trips[14]) && inject_output_overvolt_warn == $past(trips[0])))
    else $error("injection mapping wrong");
  inj_rsvd_a: assert property (@(posedge clock) disable iff (!rstn)
    (trips & 16'h2064) == 16'h0000)
    else $error("reserved bit caused a trip");
  inj_store_a: assert property (@(posedge clock) disable iff (!rstn)
    (cmd.wr && hit_inj) ##1 (cmd.rd && hit_inj && !cmd.wr) |=> (rsp.rdata == $past(cmd.wdata, 2)))
    else $error("injection word read back wrong");
endmodule

// ### sim/pmid_host.sv
// Host-side partner: issues read-word/write-word strobes and serves the settings image.
// Assumes the register group registers its answer on the edge that takes a strobe.
`timescale 1ns/1ps
module pmid_host import pmid_pkg::*; #(
  parameter int SW = 4
) (
  input  wire logic                  clock,
  output pmid_cmd_t                  cmd,
  input  wire pmid_rsp_t             rsp,
  input  wire logic [$clog2(SW)-1:0] settings_idx,
  output logic [15:0]                settings_word
);
  // =====================================================================
  // Settings image, answered combinationally at the walker index
  logic [15:0] image [SW];  // Stored settings words
  assign settings_word = image[settings_idx];

  // Idle bus and a known image at time zero
  initial begin
    cmd = '0;
    for (int i = 0; i < SW; i++) begin
      image[i] = 16'h1000 + 16'(i);
    end
  end

  // =====================================================================
  // One transfer: strobe taken at the next edge, answer read just after it
  // Checksum word is only written when a scenario asks for a refusal
  task automatic xfer(input logic rd, input logic wr, input logic [7:0] code,
                      input logic [15:0] wdata, output pmid_rsp_t r);
    @(posedge clock);
    #1;
    cmd = '{rd: rd, wr: wr, code: code, wdata: wdata};
    @(posedge clock);
    #1;
    r = rsp;
    cmd = '0;
  endtask

  // Write then read of one code on back-to-back edges
  task automatic wr_rd(input logic [7:0] code, input logic [15:0] wdata,
                       output pmid_rsp_t rw, output pmid_rsp_t rr);
    @(posedge clock);
    #1;
    cmd = '{rd: 1'b0, wr: 1'b1, code: code, wdata: wdata};
    @(posedge clock);
    #1;
    rw = rsp;
    cmd = '{rd: 1'b1, wr: 1'b0, code: code, wdata: 16'h0000};
    @(posedge clock);
    #1;
    rr = rsp;
    cmd = '0;
  endtask
endmodule

// ### sim/pmbus_checksum_faultsim_id_regs_tb.sv
// Self-checking bench for the checksum, fault-injection and identity registers.
// Assumes the host partner model and the register group share one 25 MHz clock.
`timescale 1ns/1ps
module pmbus_checksum_faultsim_id_regs_tb import pmid_pkg::*;;
  localparam int          SW  = 4;         // Shortened settings image
  localparam logic [15:0] IDV = 16'h1234;  // Arbitrary identity value
  logic clock, rstn, store_done, restore_done, fault_response, conv_enabled;
  logic comm_error_status, crc_busy;
  logic inject_overtemp_fault, inject_overcurrent_fault, inject_input_lockout, inject_input_overvolt_fault;
  logic inject_output_undervolt_fault, inject_output_overvolt_fault, inject_overcurrent_warn;
  logic inject_input_undervolt_warn, inject_output_undervolt_warn, inject_output_overvolt_warn;
  pmid_cmd_t              cmd;       // Host strobes
  pmid_rsp_t              rsp, r, r2;  // Answer and its captured copies
  logic [15:0]            settings_word, obs, mword, w;
  logic [$clog2(SW)-1:0]  settings_idx;
  logic                   arm_f, arm_w;  // Model arming of faults and warnings
  logic [31:0]            seed;
  int                     failures, cmp_count;
  // Trip outputs gathered at their injection-word bit positions
  assign obs = {1'b0, inject_overtemp_fault, 1'b0, inject_overcurrent_fault, inject_input_lockout,
                inject_input_overvolt_fault, inject_output_undervolt_fault, inject_output_overvolt_fault,
                3'b000, inject_overcurrent_warn, inject_input_undervolt_warn, 1'b0,
                inject_output_undervolt_warn, inject_output_overvolt_warn};
  pmid_host #(.SW(SW)) host_u (.clock(clock), .cmd(cmd), .rsp(rsp), .settings_idx(settings_idx),
    .settings_word(settings_word));
  pmid_regs #(.SETTINGS_WORDS(SW), .IDENT_VALUE(IDV)) dut_u (.clock(clock), .rstn(rstn), .cmd(cmd),
    .rsp(rsp), .comm_error_status(comm_error_status), .store_done(store_done), .restore_done(restore_done),
    .settings_word(settings_word), .settings_idx(settings_idx), .crc_busy(crc_busy),
    .fault_response(fault_response), .conv_enabled(conv_enabled),
    .inject_overtemp_fault(inject_overtemp_fault), .inject_overcurrent_fault(inject_overcurrent_fault),
    .inject_input_lockout(inject_input_lockout), .inject_input_overvolt_fault(inject_input_overvolt_fault),
    .inject_output_undervolt_fault(inject_output_undervolt_fault),
    .inject_output_overvolt_fault(inject_output_overvolt_fault), .inject_overcurrent_warn(inject_overcurrent_warn),
    .inject_input_undervolt_warn(inject_input_undervolt_warn),
    .inject_output_undervolt_warn(inject_output_undervolt_warn),
    .inject_output_overvolt_warn(inject_output_overvolt_warn));
  // =====================================================================
  // Reference models: xorshift stimulus, CRC-16 and trip gating
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    logic        fb;
    c = 16'h0000;
    for (int i = 0; i < SW; i++) begin
      for (int b = 15; b >= 0; b--) begin
        fb = c[15] ^ host_u.image[i][b];
        c  = {c[14:0], 1'b0} ^ (fb ? 16'h8005 : 16'h0000);
      end
    end
    return c;
  endfunction
  function automatic logic [15:0] exp_trips();
    logic [15:0] m;
    m = (mword & 16'h5f00 & {16{arm_f}}) | (mword & 16'h001b & {16{arm_w}});
    return conv_enabled ? m : (m & 16'h0900);
  endfunction
  // =====================================================================
  // Bench tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic bad);
    host_u.xfer(1'b0, 1'b1, code, d, r);
    chk("write ack", 16'h0001, {15'h0, r.ack});
    chk("write nak", {15'h0, bad}, {15'h0, r.nak});
    chk("comm error", {15'h0, bad}, {15'h0, comm_error_status});
    if (code == 8'hf1) begin
      mword = d;
      arm_f = 1'b1;
      arm_w = 1'b1;
    end
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic bad);
    host_u.xfer(1'b1, 1'b0, code, 16'h0000, r);
    chk("read ack", 16'h0001, {15'h0, r.ack});
    chk("read nak", {15'h0, bad}, {15'h0, r.nak});
    chk("read data", exp, r.rdata);
  endtask
  task automatic fresp();
    fault_response = 1'b1;
    cyc(1);
    fault_response = 1'b0;
    if (!mword[15]) arm_f = 1'b0;
    if (!mword[7]) arm_w = 1'b0;
  endtask
  task automatic tcheck();
    cyc(3);
    chk("trips", exp_trips(), obs);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // =====================================================================
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    final_report();
  end
  initial begin
    {rstn, store_done, restore_done, fault_response} = 4'b0000;
    conv_enabled = 1'b1;
    {failures, cmp_count, mword, arm_f, arm_w} = '0;
    seed = 32'h978e7247;
    repeat (8) @(posedge clock);
    #1;
    rstn = 1'b1;
    cyc(SW + 6);
    rd(8'hf0, crc_of(), 1'b0);
    rd(8'hf1, 16'h0000, 1'b0);
    // Store then restore with fresh images
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < SW; i++) begin
        seed = xs(seed);
        host_u.image[i] = seed[15:0];
      end
      if (k == 0) store_done = 1'b1;
      else restore_done = 1'b1;
      cyc(1);
      {store_done, restore_done} = 2'b00;
      cyc(2);
      chk("crc busy", 16'h0001, {15'h0, crc_busy});
      cyc(SW + 4);
      rd(8'hf0, crc_of(), 1'b0);
    end
    // Restore lands mid-walk with a new image: its walk must still run
    store_done = 1'b1;
    cyc(1);
    store_done = 1'b0;
    cyc(1);
    for (int i = 0; i < SW; i++) begin
      seed = xs(seed);
      host_u.image[i] = seed[15:0];
    end
    restore_done = 1'b1;
    cyc(1);
    restore_done = 1'b0;
    cyc(2 * SW + 8);
    rd(8'hf0, crc_of(), 1'b0);
    // Checksum refuses writes; identity accepts and ignores them
    wr(8'hf0, 16'hffff, 1'b1);
    rd(8'hf0, crc_of(), 1'b0);
    rd(8'hfc, IDV, 1'b0);
    wr(8'hfc, seed[31:16], 1'b0);
    rd(8'hfc, IDV, 1'b0);
    rd(8'h55, 16'h0000, 1'b1);
    // Every single bit, conversion on and off
    for (int c = 1; c >= 0; c--) begin
      conv_enabled = c[0];
      for (int b = 0; b < 16; b++) begin
        wr(8'hf1, 16'h0001 << b, 1'b0);
        tcheck();
        rd(8'hf1, 16'h0001 << b, 1'b0);
      end
    end
    conv_enabled = 1'b1;
    // Hold-bit combinations across two fault responses
    for (int h = 0; h < 4; h++) begin
      wr(8'hf1, 16'h5f1b | (h[0] ? 16'h8000 : 16'h0) | (h[1] ? 16'h0080 : 16'h0), 1'b0);
      tcheck();
      fresp();
      tcheck();
      fresp();
      tcheck();
    end
    // Random words, enable levels and responses
    for (int n = 0; n < 40; n++) begin
      seed = xs(seed);
      w = seed[15:0];
      if (seed[16]) wr(8'hf1, w, 1'b0);
      conv_enabled = seed[17];
      tcheck();
      if (seed[18]) fresp();
      tcheck();
      rd(8'hf1, mword, 1'b0);
    end
    // Write and read back on consecutive edges
    seed = xs(seed);
    host_u.wr_rd(8'hf1, seed[31:16], r, r2);
    chk("pair write ack", 16'h0001, {15'h0, r.ack});
    chk("pair read data", seed[31:16], r2.rdata);
    mword = seed[31:16];
    {arm_f, arm_w} = 2'b11;
    tcheck();
    // Mid-run reset clears everything and reruns the boot walk
    rstn = 1'b0;
    {mword, arm_f, arm_w} = '0;
    cyc(2);
    chk("trips in reset", 16'h0000, obs);
    chk("answer in reset", 16'h0000, {13'h0, rsp.ack, comm_error_status, crc_busy});
    rstn = 1'b1;
    cyc(SW + 6);
    rd(8'hf1, 16'h0000, 1'b0);
    rd(8'hf0, crc_of(), 1'b0);
    tcheck();
    final_report();
  end
endmodule
